// >>> common/tws_params.svh
// constants for the two-wire slave receiver: offsets, fields, resets, status codes
`ifndef TWS_PARAMS_SVH
`define TWS_PARAMS_SVH

// ==================================================================
// register offsets (word index on the plain register port)
`define TWS_OFS_OWN_ADDR   3'h0
`define TWS_OFS_CONTROL    3'h1
`define TWS_OFS_STATE      3'h2
`define TWS_OFS_BYTE       3'h3

// ==================================================================
// control register fields
`define TWS_CTL_STEP_DONE  7
`define TWS_CTL_ACK_EN     6
`define TWS_CTL_START_REQ  5
`define TWS_CTL_STOP_REQ   4
`define TWS_CTL_WCOL       3
`define TWS_CTL_IF_EN      2
`define TWS_CTL_IRQ_EN     0

// ==================================================================
// reset values
`define TWS_RST_OWN_ADDR   8'hFE
`define TWS_RST_CONTROL    8'h00
`define TWS_RST_BYTE       8'hFF

// ==================================================================
// status codes, prescaler bits zero
`define TWS_ST_OWN_W       8'h60
`define TWS_ST_ARB_OWN_W   8'h68
`define TWS_ST_GC          8'h70
`define TWS_ST_ARB_GC      8'h78
`define TWS_ST_DATA_ACK    8'h80
`define TWS_ST_DATA_NACK   8'h88
`define TWS_ST_GC_ACK      8'h90
`define TWS_ST_GC_NACK     8'h98
`define TWS_ST_IDLE        8'hF8
`define TWS_ST_PRESC_MASK  8'hF8

// ==================================================================
// bus constants
`define TWS_GC_ADDR        7'h00
`define TWS_BITS_PER_BYTE  4'h8

`endif

// >>> common/tws_pkg.sv
// types shared by the two-wire slave receiver
package tws_pkg;

    // ==============================================================
    // receiver sequencer, gray coded along the usual path
    typedef enum logic [2:0] {
        TWS_IDLE     = 3'h0,
        TWS_ADDR     = 3'h1,
        TWS_ADDR_ACK = 3'h3,
        TWS_DATA     = 3'h2,
        TWS_DATA_ACK = 3'h6
    } tws_state_t;

    // ==============================================================
    // one request on the plain register port
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [2:0] addr;
        logic [7:0] wdata;
    } tws_bus_req_t;

    // ==============================================================
    // one open-drain pin toward the pad: oe_n low means pulled low
    typedef struct packed {
        logic out;
        logic oe_n;
    } tws_pin_drv_t;

endpackage

// >>> src/tws_slave_rx.sv
// two-wire slave receiver with register port, address match and clock stretching
`timescale 1ns/1ps
`default_nettype none
`include "tws_params.svh"

// What this block does
// - answer when upper seven own-address bits equal received address
// - own-address bit zero set enables answering general call address 0x00
// - acknowledge own or general call address only while ack enable is one
// - once addressed, write direction enters receive mode, read enters transmit mode
// - own address with write bit sets step flag and valid status
// - status always reported with prescaler bits reading zero
// - status 0x60 after own address write acknowledged
// - status 0x68 when addressed for write after master arbitration loss
// - status 0x70 after general call acknowledged
// - status 0x78 when general call follows master arbitration loss
// - status 0x80 after acknowledged data byte, byte readable in data register
// - after flag clear, next byte is acked per ack enable
// - ack enable cleared mid transfer gives NACK after next data byte
// - ack enable zero ignores own address but bus stays monitored
// - in deep sleep with ack enable set, address still matched and acked
// - after a sleep match, SCL held low until flag cleared by one
// - data register need not hold last bus byte after wake-up
// - status 0x88 after NACKed own data byte, then not-addressed mode
// - status 0x90 after acknowledged general call data byte
module tws_slave_rx
    import tws_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              rst,
    input  wire tws_pkg::tws_bus_req_t bus_req,
    output var  logic [7:0]        rdata,
    input  wire logic              scl_in,
    output var  tws_pkg::tws_pin_drv_t scl_drv,
    input  wire logic              sda_in,
    output var  tws_pkg::tws_pin_drv_t sda_drv,
    input  wire logic              arb_lost,
    input  wire logic              deep_sleep,
    output var  logic              wake_request,
    output var  logic              target_transmit_mode,
    output var  logic              irq
);
    import tws_pkg::*;

    // ==============================================================
    // helpers
    function automatic logic addr_hit(input logic [7:0] rx, input logic [7:0] own);
        addr_hit = (rx[7:1] == own[7:1]) || (own[0] && rx[7:1] == `TWS_GC_ADDR);
    endfunction

    function automatic logic [7:0] rx_status(input logic gc, input logic acked);
        if (gc) begin
            rx_status = acked ? `TWS_ST_GC_ACK : `TWS_ST_GC_NACK;
        end else begin
            rx_status = acked ? `TWS_ST_DATA_ACK : `TWS_ST_DATA_NACK;
        end
    endfunction

    // ==============================================================
    // registers
    logic [7:0]  own_slave_address;
    logic [7:0]  bus_byte_register;
    logic [7:0]  bus_state_register;
    logic        step_done_flag;
    logic        ack_enable;
    logic        start_request;
    logic        stop_request;
    logic        interface_enable;
    logic        irq_enable;
    localparam logic [7:0] CTL_RST = `TWS_RST_CONTROL;

    // ==============================================================
    // pin synchronisers and edge finding
    logic        scl_meta, scl_sync, scl_prev;
    logic        sda_meta, sda_sync, sda_prev;
    logic        scl_rise, scl_fall, bus_start, bus_stop;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            scl_meta <= 1'b1;
            scl_sync <= 1'b1;
            scl_prev <= 1'b1;
            sda_meta <= 1'b1;
            sda_sync <= 1'b1;
            sda_prev <= 1'b1;
        end else begin
            scl_meta <= scl_in;
            scl_sync <= scl_meta;
            scl_prev <= scl_sync;
            sda_meta <= sda_in;
            sda_sync <= sda_meta;
            sda_prev <= sda_sync;
        end
    end

    assign scl_rise  = scl_sync & ~scl_prev;
    assign scl_fall  = ~scl_sync & scl_prev;
    // data moving while the clock is high marks start and stop
    assign bus_start = scl_sync & scl_prev & sda_prev & ~sda_sync;
    assign bus_stop  = scl_sync & scl_prev & ~sda_prev & sda_sync;

    // ==============================================================
    // receive sequencer
    tws_state_t  state;
    logic [3:0]  bit_cnt;
    logic [7:0]  shift;
    logic        gc_mode;
    logic        acked;
    logic        arb_seen;
    logic        ctl_write, flag_clear, flag_set;
    logic        byte_done, addr_match, ack_data;

    assign ctl_write  = bus_req.wr && bus_req.addr == `TWS_OFS_CONTROL;
    assign flag_clear = ctl_write && bus_req.wdata[`TWS_CTL_STEP_DONE];
    assign byte_done  = scl_fall && bit_cnt == `TWS_BITS_PER_BYTE;
    // enable and ack enable gate recognition; with ack enable zero the bus is still followed, with enable zero the sequencer stays idle
    assign addr_match = addr_hit(shift, own_slave_address) && ack_enable
                        && interface_enable;
    assign ack_data   = ack_enable;
    assign flag_set   = scl_fall && (state == TWS_ADDR_ACK || state == TWS_DATA_ACK);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state   <= TWS_IDLE;
            bit_cnt <= 4'h0;
            shift   <= 8'h00;
            gc_mode <= 1'b0;
            acked   <= 1'b0;
        end else if (!interface_enable || bus_stop) begin
            state   <= TWS_IDLE;
            bit_cnt <= 4'h0;
        end else if (bus_start) begin
            state   <= TWS_ADDR;
            bit_cnt <= 4'h0;
        end else begin
            if (scl_rise && (state == TWS_ADDR || state == TWS_DATA)) begin
                shift   <= {shift[6:0], sda_sync};
                bit_cnt <= bit_cnt + 4'h1;
            end
            case (state)
                TWS_ADDR: begin
                    if (byte_done) begin
                        bit_cnt <= 4'h0;
                        gc_mode <= shift[7:1] == `TWS_GC_ADDR;
                        // write direction continues here; read belongs to the transmitter
                        state   <= (addr_match && !shift[0]) ? TWS_ADDR_ACK : TWS_IDLE;
                    end
                end
                TWS_ADDR_ACK: begin
                    if (scl_fall) begin
                        state <= TWS_DATA;
                    end
                end
                TWS_DATA: begin
                    if (byte_done) begin
                        bit_cnt <= 4'h0;
                        acked   <= ack_data;
                        state   <= TWS_DATA_ACK;
                    end
                end
                TWS_DATA_ACK: begin
                    if (scl_fall) begin
                        state <= acked ? TWS_DATA : TWS_IDLE;
                    end
                end
                default: begin
                    state <= TWS_IDLE;
                end
            endcase
        end
    end

    // ==============================================================
    // arbitration loss from the master side colours the next address status
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            arb_seen <= 1'b0;
        end else if (arb_lost) begin
            arb_seen <= 1'b1;
        end else if (flag_set || bus_stop) begin
            arb_seen <= 1'b0;
        end
    end

    // ==============================================================
    // transmit direction hand-off
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            target_transmit_mode <= 1'b0;
        end else if (state == TWS_ADDR && byte_done && addr_match && shift[0]) begin
            target_transmit_mode <= 1'b1;
        end else if (bus_stop || bus_start || !interface_enable) begin
            target_transmit_mode <= 1'b0;
        end
    end

    // ==============================================================
    // step flag and status
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            step_done_flag <= 1'b0;
        end else if (flag_set) begin
            step_done_flag <= 1'b1;
        end else if (flag_clear) begin
            step_done_flag <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            bus_state_register <= `TWS_ST_IDLE;
        end else if (flag_set && state == TWS_ADDR_ACK) begin
            if (gc_mode) begin
                bus_state_register <= arb_seen ? `TWS_ST_ARB_GC : `TWS_ST_GC;
            end else begin
                bus_state_register <= arb_seen ? `TWS_ST_ARB_OWN_W : `TWS_ST_OWN_W;
            end
        end else if (flag_set) begin
            bus_state_register <= rx_status(gc_mode, acked);
        end else if (flag_clear) begin
            bus_state_register <= `TWS_ST_IDLE;
        end
    end

    // a byte caught while the core sleeps is dropped; software must not trust it
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            bus_byte_register <= `TWS_RST_BYTE;
        end else if (flag_set && state == TWS_DATA_ACK && !deep_sleep) begin
            bus_byte_register <= shift;
        end else if (bus_req.wr && bus_req.addr == `TWS_OFS_BYTE) begin
            bus_byte_register <= bus_req.wdata;
        end
    end

    // ==============================================================
    // sleep wake-up: match still works on the sampled bus clock
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wake_request <= 1'b0;
        end else if (deep_sleep && state == TWS_ADDR && byte_done && addr_match) begin
            wake_request <= 1'b1;
        end else if (!deep_sleep) begin
            wake_request <= 1'b0;
        end
    end

    // ==============================================================
    // pin drive: ack pulls data low, a pending step holds the clock low unless the sequencer is idle
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sda_drv <= '{out: 1'b0, oe_n: 1'b1};
            scl_drv <= '{out: 1'b0, oe_n: 1'b1};
        end else begin
            sda_drv.out  <= 1'b0;
            scl_drv.out  <= 1'b0;
            sda_drv.oe_n <= !((state == TWS_ADDR_ACK) || (state == TWS_DATA_ACK && acked));
            // long wake-up start times stretch the bus for just as long
            scl_drv.oe_n <= !(step_done_flag && !flag_clear && state != TWS_IDLE);
        end
    end

    // ==============================================================
    // register port
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            own_slave_address <= `TWS_RST_OWN_ADDR;
        end else if (bus_req.wr && bus_req.addr == `TWS_OFS_OWN_ADDR) begin
            own_slave_address <= bus_req.wdata;
        end
    end

    // software prepares reception through these bits
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ack_enable       <= CTL_RST[`TWS_CTL_ACK_EN];
            start_request    <= 1'b0;
            stop_request     <= 1'b0;
            interface_enable <= 1'b0;
            irq_enable       <= 1'b0;
        end else if (ctl_write) begin
            ack_enable       <= bus_req.wdata[`TWS_CTL_ACK_EN];
            start_request    <= bus_req.wdata[`TWS_CTL_START_REQ];
            stop_request     <= bus_req.wdata[`TWS_CTL_STOP_REQ];
            interface_enable <= bus_req.wdata[`TWS_CTL_IF_EN];
            irq_enable       <= bus_req.wdata[`TWS_CTL_IRQ_EN];
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rdata <= 8'h00;
        end else if (bus_req.rd) begin
            case (bus_req.addr)
                `TWS_OFS_OWN_ADDR: rdata <= own_slave_address;
                `TWS_OFS_CONTROL:  rdata <= {step_done_flag, ack_enable, start_request,
                                             stop_request, 1'b0, interface_enable,
                                             1'b0, irq_enable};
                `TWS_OFS_STATE:    rdata <= bus_state_register & `TWS_ST_PRESC_MASK;
                `TWS_OFS_BYTE:     rdata <= bus_byte_register;
                default:           rdata <= 8'h00;
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= step_done_flag && irq_enable;
        end
    end

    // ==============================================================
    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    flag_on_ack_a: assert property (flag_set |=> step_done_flag)
        else $error("step flag not set after ack bit");
    set_wins_a: assert property (flag_set && flag_clear |=> step_done_flag)
        else $error("clear beat a same-cycle set");
    clear_flag_a: assert property (flag_clear && !flag_set |=> !step_done_flag)
        else $error("flag not cleared by writing one");
    presc_zero_a: assert property (bus_req.rd |=> rdata[1:0] == 2'b00
                                   || $past(bus_req.addr) != `TWS_OFS_STATE)
        else $error("prescaler bits visible in status");
    own_status_a: assert property (flag_set && state == TWS_ADDR_ACK && !gc_mode
                                   && !arb_seen |=> bus_state_register == `TWS_ST_OWN_W)
        else $error("own address status wrong");
    gc_status_a: assert property (flag_set && state == TWS_ADDR_ACK && gc_mode
                                  && !arb_seen |=> bus_state_register == `TWS_ST_GC)
        else $error("general call status wrong");
    nack_idle_a: assert property (flag_set && state == TWS_DATA_ACK && !acked
                                  && !bus_start && !bus_stop |=> state == TWS_IDLE)
        else $error("not idle after nacked byte");
    no_ack_off_a: assert property (state == TWS_ADDR && byte_done && !ack_enable
                                   |=> state != TWS_ADDR_ACK)
        else $error("address acked with ack disabled");
    data_nack_a: assert property (state == TWS_DATA && byte_done && !ack_enable && !bus_stop
                                  && !bus_start && interface_enable |=> ##1 sda_drv.oe_n)
        else $error("data byte acked with ack disabled");
    stretch_a: assert property (step_done_flag && !flag_clear && state != TWS_IDLE
                                |=> !scl_drv.oe_n)
        else $error("clock not held while step pending");
    irq_a: assert property (step_done_flag && irq_enable |=> irq)
        else $error("interrupt not raised");

    addr_cov: cover property (flag_set && state == TWS_ADDR_ACK);
    data_cov: cover property (flag_set && state == TWS_DATA_ACK && acked);
    nack_cov: cover property (flag_set && state == TWS_DATA_ACK && !acked);
    wake_cov: cover property (!wake_request ##1 wake_request);

endmodule
`default_nettype wire

// >>> verif/two_wire_slave_receiver_test.sv
// self-checking bench for the two-wire slave receiver
`timescale 1ns/1ps
`default_nettype none

module two_wire_slave_receiver_test;
    import tws_pkg::*;

    logic          sys_clk = 1'b0;
    logic          rst = 1'b1;
    tws_bus_req_t  bus_req = '0;
    logic [7:0]    rdata;
    tws_pin_drv_t  scl_drv;
    tws_pin_drv_t  sda_drv;
    logic          arb_lost = 1'b0;
    logic          deep_sleep = 1'b0;
    logic          wake_request;
    logic          target_transmit_mode;
    logic          irq;
    logic          m_scl;
    logic          m_sda;
    wire logic     scl_line = m_scl & scl_drv.oe_n;
    wire logic     sda_line = m_sda & sda_drv.oe_n;
    int            errors = 0;
    int            n_checks = 0;
    int            cycles = 0;
    logic          ack;
    logic          m_stuck;

    always #50 sys_clk = ~sys_clk;

    tws_slave_rx DUT (.sys_clk(sys_clk), .rst(rst), .bus_req(bus_req), .rdata(rdata),
        .scl_in(scl_line), .scl_drv(scl_drv), .sda_in(sda_line), .sda_drv(sda_drv),
        .arb_lost(arb_lost), .deep_sleep(deep_sleep), .wake_request(wake_request),
        .target_transmit_mode(target_transmit_mode), .irq(irq));

    tws_master_model master (.scl_rel(m_scl), .sda_rel(m_sda), .scl_line(scl_line),
        .sda_line(sda_line), .stuck(m_stuck));

    // ==============================================================
    // reporting
    task automatic results();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 30000) begin
            errors++;
            $display("[FAIL] timeout expected finish seen hang");
            results();
        end
    end

    task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk1(input string nm, input logic e, input logic g);
        chk8(nm, {7'h00, e}, {7'h00, g});
    endtask

    // ==============================================================
    // register port
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge sys_clk);
        bus_req <= '0;
    endtask

    task automatic rd_chk(input string nm, input logic [2:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge sys_clk);
        bus_req <= '0;
        #1;
        chk8(nm, e, rdata);
    endtask

    task automatic settle();
        repeat (10) @(posedge sys_clk);
    endtask

    task automatic addr(input logic [7:0] b, input logic e);
        master.start();
        master.send_byte(b, ack);
        chk1("addr_ack", e, ack);
        settle();
    endtask

    // ==============================================================
    // scenarios
    task automatic t_reset();
        rd_chk("own_rst", 3'h0, 8'hFE);
        rd_chk("ctl_rst", 3'h1, 8'h00);
        rd_chk("state_rst", 3'h2, 8'hF8);
        rd_chk("byte_rst", 3'h3, 8'hFF);
        rd_chk("unmapped", 3'h5, 8'h00);
        chk1("pin_out", 1'b0, scl_drv.out | sda_drv.out);
    endtask

    task automatic t_own_write();
        wr(3'h0, 8'h60);
        wr(3'h1, 8'hC5);
        addr(8'h60, 1'b0);
        rd_chk("state_own", 3'h2, 8'h60);
        rd_chk("flag_set", 3'h1, 8'hC5);
        chk1("irq", 1'b1, irq);
        chk1("stretch", 1'b0, scl_drv.oe_n);
        wr(3'h1, 8'h45);
        rd_chk("flag_kept", 3'h1, 8'hC5);
        wr(3'h1, 8'hC5);
        repeat (3) @(posedge sys_clk);
        chk1("released", 1'b1, scl_drv.oe_n);
        chk1("irq_off", 1'b0, irq);
        master.send_byte(8'hA5, ack);
        chk1("data_ack", 1'b0, ack);
        settle();
        rd_chk("state_data", 3'h2, 8'h80);
        rd_chk("data_byte", 3'h3, 8'hA5);
        wr(3'h1, 8'h85);
        master.send_byte(8'h3C, ack);
        chk1("data_nack", 1'b1, ack);
        settle();
        rd_chk("state_nack", 3'h2, 8'h88);
        wr(3'h1, 8'hC5);
        master.stop();
    endtask

    task automatic t_filter();
        addr(8'h00, 1'b1);
        master.stop();
        addr(8'h62, 1'b1);
        master.stop();
        rd_chk("state_idle", 3'h2, 8'hF8);
    endtask

    task automatic t_gc();
        wr(3'h0, 8'h61);
        addr(8'h00, 1'b0);
        rd_chk("state_gc", 3'h2, 8'h70);
        wr(3'h1, 8'hC5);
        master.send_byte(8'h5A, ack);
        chk1("gc_data_ack", 1'b0, ack);
        settle();
        rd_chk("state_gc_data", 3'h2, 8'h90);
        rd_chk("gc_byte", 3'h3, 8'h5A);
        wr(3'h1, 8'hC5);
        master.stop();
    endtask

    task automatic t_ack_off();
        wr(3'h1, 8'h85);
        addr(8'h60, 1'b1);
        master.stop();
        wr(3'h1, 8'hC5);
        addr(8'h60, 1'b0);
        rd_chk("state_resume", 3'h2, 8'h60);
        wr(3'h1, 8'hC5);
        master.stop();
    endtask

    task automatic t_arb(input logic [7:0] b, input logic [7:0] e);
        @(posedge sys_clk);
        arb_lost <= 1'b1;
        @(posedge sys_clk);
        arb_lost <= 1'b0;
        addr(b, 1'b0);
        rd_chk("state_arb", 3'h2, e);
        wr(3'h1, 8'hC5);
        master.stop();
    endtask

    task automatic t_read_dir();
        addr(8'h61, 1'b1);
        chk1("tx_mode", 1'b1, target_transmit_mode);
        master.stop();
        settle();
        chk1("tx_mode_off", 1'b0, target_transmit_mode);
    endtask

    task automatic t_sleep();
        @(posedge sys_clk);
        deep_sleep <= 1'b1;
        addr(8'h60, 1'b0);
        chk1("wake", 1'b1, wake_request);
        chk1("sleep_hold", 1'b0, scl_drv.oe_n);
        deep_sleep <= 1'b0;
        settle();
        chk1("wake_hold", 1'b0, scl_drv.oe_n);
        chk1("wake_off", 1'b0, wake_request);
        wr(3'h1, 8'hC5);
        deep_sleep <= 1'b1;
        repeat (3) @(posedge sys_clk);
        chk1("wake_release", 1'b1, scl_drv.oe_n);
        master.send_byte(8'h96, ack);
        chk1("sleep_ack", 1'b0, ack);
        settle();
        rd_chk("sleep_byte", 3'h3, 8'h5A);
        wr(3'h1, 8'hC5);
        deep_sleep <= 1'b0;
        master.stop();
    endtask

    // ==============================================================
    // main sequence
    initial begin
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        #37;
        t_reset();
        t_own_write();
        t_filter();
        t_gc();
        t_ack_off();
        t_arb(8'h60, 8'h68);
        t_arb(8'h00, 8'h78);
        t_read_dir();
        t_sleep();
        chk1("bus_stuck", 1'b0, m_stuck);
        results();
    end
endmodule
`default_nettype wire

// >>> verif/tws_master_model.sv
// bus master transmitter model driving the two open-drain lines
`timescale 1ns/1ps
`default_nettype none

// ==================================================================
// released lines float high through the pull-ups
module tws_master_model (
    output var  logic scl_rel,
    output var  logic sda_rel,
    input  wire logic scl_line,
    input  wire logic sda_line,
    output var  logic stuck
);
    localparam time HALF = 400;

    initial begin
        scl_rel = 1'b1;
        sda_rel = 1'b1;
        stuck   = 1'b0;
    end

    // bounded, so a stuck stretch cannot hang the run
    task automatic wait_high();
        int n;
        n = 0;
        while (scl_line !== 1'b1 && n < 2000) begin
            #100;
            n++;
        end
        // a stretch that never ends must not pass silently
        if (n >= 2000) stuck = 1'b1;
    endtask

    task automatic start();
        #HALF;
        sda_rel = 1'b0;
        #HALF;
        scl_rel = 1'b0;
    endtask

    // msb first, sda only moves in the middle of the low phase
    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            #(HALF / 2);
            sda_rel = b[i];
            #(HALF / 2);
            scl_rel = 1'b1;
            wait_high();
            #HALF;
            scl_rel = 1'b0;
        end
        #(HALF / 2);
        sda_rel = 1'b1;
        #(HALF / 2);
        scl_rel = 1'b1;
        wait_high();
        #(HALF / 2);
        ack = sda_line;
        #(HALF / 2);
        scl_rel = 1'b0;
    endtask

    task automatic stop();
        #(HALF / 2);
        sda_rel = 1'b0;
        #(HALF / 2);
        scl_rel = 1'b1;
        wait_high();
        #HALF;
        sda_rel = 1'b1;
        #HALF;
    endtask
endmodule
`default_nettype wire
